// ===== hw/atwr_readout.sv
/*
 * atwr_readout: two-wire conversion readout of a converter, with an apb
 * slave for control and status.
 * assumes sclk and powerdown_reset_n are asynchronous pins, and that the
 * filter presents a settled result on filt_result at every completion.
 */
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
module atwr_readout
    import atwr_pkg::*;
#(
    parameter int         STARTUP_C = STARTUP_CYC,
    parameter int         SETTLE_C  = SETTLE_CYC,
    parameter int         PERIOD_C  = PERIOD_CYC,
    parameter int         GUARD_C   = GUARD_CYC,
    parameter logic [1:0] IDENT     = IDENT_CODE
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // apb slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    // filter result
    input  wire atwr_result_s filt_result,
    // device pins
    input  wire logic         powerdown_reset_n,
    input  wire logic         sclk,
    output logic              data_out_ready_n_o,
    output logic              data_out_ready_n_oe
);

    typedef enum logic [1:0] {ST_OFF, ST_WAKE, ST_RUN} atwr_state_e;

    atwr_state_e  state_reg;
    logic [31:0]  cnt_reg;
    logic [7:0]   pd_cnt_reg;
    logic         avail_reg;
    logic         shifting_reg;
    logic [4:0]   bit_cnt_reg;
    logic         dout_reg;
    logic         oe_reg;
    logic [31:0]  ctrl_reg;
    logic [15:0]  conv_count_reg;
    atwr_result_s last_reg;
    logic [31:0]  prdata_reg;
    logic         pslverr_reg;

    logic         pd_lvl;
    logic         sclk_rise;
    logic         sclk_fall;
    logic         pd_req;
    logic         pd_fire;
    logic         conv_done;
    logic         guard_on;
    logic         word_done;
    logic [23:0]  word_next;
    logic [23:0]  word_now;
    logic         sh_msb;
    logic         dout_next;
    logic         wr_en;
    logic         rd_setup;

    // pin synchronisers
    atwr_sync #(.INIT(1'b1)) u_pd_sync (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .async_in (powerdown_reset_n),
        .level_o  (pd_lvl),
        .rise_o   (),
        .fall_o   ()
    );

    atwr_sync #(.INIT(1'b1)) u_sclk_sync (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .async_in (sclk),
        .level_o  (),
        .rise_o   (sclk_rise),
        .fall_o   (sclk_fall)
    );

    // power-down request from the pin or the software hold bit
    assign pd_req  = !pd_lvl || ctrl_reg[CTRL_HOLD_BIT];
    assign pd_fire = pd_req && (pd_cnt_reg == 8'(PD_MIN_CYC - 1));

    // measure the length of a power-down low
    always_ff @(posedge clk_sys) begin
        if (rst || !pd_req) begin
            pd_cnt_reg <= 8'h00;
        end else if (pd_cnt_reg != 8'(PD_MIN_CYC - 1)) begin
            pd_cnt_reg <= pd_cnt_reg + 8'h01;
        end
    end

    // conversion timing: startup, settle, then fixed period
    assign conv_done = (state_reg == ST_RUN) && (cnt_reg == 32'h0000_0000);
    assign guard_on  = (state_reg == ST_RUN) && (cnt_reg < 32'(GUARD_C));

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= ST_OFF;
            cnt_reg   <= 32'h0000_0000;
        end else if (pd_fire) begin
            state_reg <= ST_OFF;
            cnt_reg   <= 32'h0000_0000;
        end else begin
            unique case (state_reg)
                ST_OFF: begin
                    if (!pd_req) begin
                        state_reg <= ST_WAKE;
                        cnt_reg   <= 32'(STARTUP_C - 1);
                    end
                end
                ST_WAKE: begin
                    if (cnt_reg == 32'h0000_0000) begin
                        state_reg <= ST_RUN;
                        cnt_reg   <= 32'(SETTLE_C - 1);
                    end else begin
                        cnt_reg <= cnt_reg - 32'h0000_0001;
                    end
                end
                ST_RUN: begin
                    if (conv_done) begin
                        cnt_reg <= 32'(PERIOD_C - 1);
                    end else begin
                        cnt_reg <= cnt_reg - 32'h0000_0001;
                    end
                end
            endcase
        end
    end

    // assemble the serial word: result then status byte
    assign word_next = {filt_result.code,
                        STAT_READY,
                        STAT_ZERO,
                        filt_result.range_err,
                        IDENT,
                        CHECK_PATTERN};

    atwr_shifter #(.W(WORD_BITS)) u_shifter (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .load      (conv_done),
        .load_word (word_next),
        .shift     (sclk_fall && shifting_reg && (bit_cnt_reg != 5'h00)),
        .word_o    (word_now),
        .msb_o     (sh_msb)
    );

    // last rising edge of a word
    assign word_done = sclk_rise && shifting_reg &&
                       (bit_cnt_reg == 5'(WORD_BITS - 1));

    // readout state: available, shifting, bits taken by the host
    always_ff @(posedge clk_sys) begin
        if (rst || pd_fire || state_reg != ST_RUN) begin
            avail_reg    <= 1'b0;
            shifting_reg <= 1'b0;
            bit_cnt_reg  <= 5'h00;
        end else if (conv_done) begin
            avail_reg    <= 1'b1;
            shifting_reg <= 1'b0;
            bit_cnt_reg  <= 5'h00;
        end else if (guard_on && avail_reg && !shifting_reg) begin
            avail_reg <= 1'b0;
        end else if (sclk_fall && avail_reg && !shifting_reg) begin
            shifting_reg <= 1'b1;
        end else if (word_done) begin
            shifting_reg <= 1'b0;
            avail_reg    <= 1'b0;
            bit_cnt_reg  <= 5'h00;
        end else if (sclk_rise && shifting_reg) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
    end

    // one pin: ready low, then data bits, else high
    always_comb begin
        if (shifting_reg) begin
            dout_next = sh_msb;
        end else if (avail_reg) begin
            dout_next = 1'b0;
        end else begin
            dout_next = 1'b1;
        end
    end

    // registered pin drive and enable
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dout_reg <= 1'b1;
            oe_reg   <= 1'b0;
        end else begin
            dout_reg <= dout_next;
            oe_reg   <= (state_reg != ST_OFF) && !pd_req;
        end
    end

    assign data_out_ready_n_o  = dout_reg;
    assign data_out_ready_n_oe = oe_reg;

    // capture last result and count completions for software
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            last_reg       <= '0;
            conv_count_reg <= 16'h0000;
        end else if (conv_done) begin
            last_reg       <= filt_result;
            conv_count_reg <= conv_count_reg + 16'h0001;
        end
    end

    // apb: zero wait states, write at access phase
    assign wr_en    = psel && penable && pwrite;
    assign rd_setup = psel && !penable;
    assign pready   = 1'b1;
    assign prdata   = prdata_reg;
    assign pslverr  = pslverr_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_en && paddr == OFS_CTRL) begin
            ctrl_reg <= {31'h0000_0000, pwdata[CTRL_HOLD_BIT]};
        end
    end

    // read data and error decoded in the setup phase
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (rd_setup) begin
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            unique case (paddr)
                OFS_CTRL:   prdata_reg <= ctrl_reg;
                OFS_STATUS: prdata_reg <= {23'h00_0000, bit_cnt_reg,
                                           shifting_reg, avail_reg,
                                           state_reg == ST_RUN,
                                           state_reg != ST_OFF};
                OFS_RESULT: prdata_reg <= {13'h0000, IDENT,
                                           last_reg.range_err,
                                           last_reg.code};
                OFS_COUNT:  prdata_reg <= {16'h0000, conv_count_reg};
                default:    pslverr_reg <= 1'b1;
            endcase
        end
    end

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_tri_when_down: assert property (
        pd_req |=> !data_out_ready_n_oe)
        else $error("pin driven while powered down");

    a_ready_low_load: assert property (
        conv_done && !pd_fire |=> ##1 (data_out_ready_n_o == 1'b0))
        else $error("ready not shown after load");

    a_high_after_read: assert property (
        word_done && !conv_done |=> ##1 data_out_ready_n_o)
        else $error("pin not high after word read");

    a_guard_blanks: assert property (
        guard_on && !shifting_reg && !conv_done |=> ##1 data_out_ready_n_o)
        else $error("unread word shown during update guard");

    a_status_byte: assert property (
        conv_done && !pd_fire |=> word_now[7:0] ==
            {2'h0, $past(filt_result.range_err), IDENT, 3'h5})
        else $error("status byte wrong after load");

    a_result_field: assert property (
        conv_done && !pd_fire |=> word_now[23:8] == $past(filt_result.code))
        else $error("result field wrong after load");

    a_read_once: assert property (
        !avail_reg && !conv_done |=> !avail_reg)
        else $error("result offered twice");

    a_wake_high: assert property (
        state_reg == ST_WAKE && !pd_req |=>
            (data_out_ready_n_o && data_out_ready_n_oe))
        else $error("pin not high during wake");

    a_settle_load: assert property (
        state_reg == ST_WAKE && cnt_reg == 32'h0000_0000 && !pd_fire
            |=> state_reg == ST_RUN && cnt_reg == 32'(SETTLE_C - 1))
        else $error("settle count wrong");

    a_period_load: assert property (
        conv_done && !pd_fire |=> cnt_reg == 32'(PERIOD_C - 1))
        else $error("conversion period wrong");

    a_pd_reset: assert property (
        pd_fire |=> state_reg == ST_OFF && !avail_reg)
        else $error("power-down did not reset");

    a_msb_first: assert property (
        sclk_fall && avail_reg && !shifting_reg && !guard_on && !conv_done
            && !pd_fire
            |=> ##1 data_out_ready_n_o == $past(word_now[23], 2))
        else $error("first bit not result msb");

endmodule

// ===== hw/atwr_pkg.sv
/*
 * atwr_pkg: constants, register map and carrier types for the two-wire
 * conversion readout block.
 * assumes a 250 MHz system clock; all counts derive from that rate.
 */
package atwr_pkg;

    // system clock rate
    localparam int CLK_HZ       = 250_000_000;
    localparam int CLK_MHZ      = CLK_HZ / 1_000_000;

    // power-up, settling, conversion rate and guard times
    localparam int T_STARTUP_US = 1000;
    localparam int T_SETTLE_US  = 24000;
    localparam int OUT_RATE_HZ  = 125;
    localparam int T_GUARD_US   = 20;
    localparam int T_PD_MIN_NS  = 100;

    // derived cycle counts: least times round up, longest round down
    localparam int STARTUP_CYC  = T_STARTUP_US * CLK_MHZ;
    localparam int SETTLE_CYC   = T_SETTLE_US * CLK_MHZ;
    localparam int PERIOD_CYC   = CLK_HZ / OUT_RATE_HZ;
    localparam int GUARD_CYC    = T_GUARD_US * CLK_MHZ;
    localparam int PD_MIN_CYC   = (T_PD_MIN_NS * CLK_MHZ + 999) / 1000;

    // serial word layout
    localparam int WORD_BITS    = 24;
    localparam int RESULT_BITS  = 16;
    localparam logic       STAT_READY   = 1'b0;
    localparam logic       STAT_ZERO    = 1'b0;
    localparam logic [2:0] CHECK_PATTERN = 3'h5;
    // identification code: value is arbitrary
    localparam logic [1:0] IDENT_CODE   = 2'h2;

    // apb register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STATUS   = 8'h04;
    localparam logic [7:0] OFS_RESULT   = 8'h08;
    localparam logic [7:0] OFS_COUNT    = 8'h0C;

    // control register fields and reset value
    localparam int         CTRL_HOLD_BIT = 0;
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;

    // result delivered by the filter at each conversion completion
    typedef struct packed {
        logic [15:0] code;
        logic        range_err;
    } atwr_result_s;

endpackage

// ===== hw/atwr_sync.sv
/*
 * atwr_sync: three-flop synchroniser with agreement filter and edge pulses.
 * assumes the input is asynchronous to clk_sys; INIT is the idle level.
 */
`timescale 1ns/1ps
module atwr_sync #(
    parameter logic INIT = 1'b1
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // raw input and filtered outputs
    input  wire logic async_in,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);

    logic ff1_reg;
    logic ff2_reg;
    logic ff3_reg;
    logic lvl_reg;

    // three flops; a change counts once flops two and three agree
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ff1_reg <= INIT;
            ff2_reg <= INIT;
            ff3_reg <= INIT;
            lvl_reg <= INIT;
        end else begin
            ff1_reg <= async_in;
            ff2_reg <= ff1_reg;
            ff3_reg <= ff2_reg;
            if (ff2_reg == ff3_reg) begin
                lvl_reg <= ff3_reg;
            end
        end
    end

    // edges of the accepted level
    assign level_o = lvl_reg;
    assign rise_o  = (ff2_reg == ff3_reg) && ff3_reg && !lvl_reg;
    assign fall_o  = (ff2_reg == ff3_reg) && !ff3_reg && lvl_reg;

endmodule

// ===== hw/atwr_shifter.sv
/*
 * atwr_shifter: parallel-load shift register, msb first, ones shifted in.
 * assumes load and shift come from logic on clk_sys.
 */
`timescale 1ns/1ps
module atwr_shifter #(
    parameter int W = 24
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // control and data
    input  wire logic         load,
    input  wire logic [W-1:0] load_word,
    input  wire logic         shift,
    output logic [W-1:0]      word_o,
    output logic              msb_o
);

    logic [W-1:0] word_reg;

    // load wins over shift
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            word_reg <= '1;
        end else if (load) begin
            word_reg <= load_word;
        end else if (shift) begin
            word_reg <= {word_reg[W-2:0], 1'b1};
        end
    end

    assign word_o = word_reg;
    assign msb_o  = word_reg[W-1];

endmodule

// ===== tb/atwr_host.sv
/*
 * atwr_host: behavioural host controller on the far side of the link.
 * assumes the bench resolves the shared pin and calls read_word.
 */
`timescale 1ns/1ps
module atwr_host (
    // link pins
    output logic      sclk,
    input  wire logic dout
);
    // serial clock idles high outside frames
    initial sclk = 1'b1;

    // waits for ready low, then 24 pulses of a 64 ns clock
    task automatic read_word(input int wait_ns, output logic [23:0] w,
                             output logic seen, output logic ok);
        int t;
        t = 0;
        w = 24'h000000;
        while (dout !== 1'b0 && t < wait_ns) begin
            #4;
            t = t + 4;
        end
        seen = (dout === 1'b0);
        ok = 1'b0;
        if (seen) begin
            #1;
            // whole word well inside one period
            for (int i = 0; i < 24; i++) begin
                #32 sclk = 1'b0;
                #32 sclk = 1'b1;
                w = {w[22:0], dout}; // sample on rise
            end
            ok = (w[2:0] === 3'h5); // transfer check
        end
    endtask
endmodule

// ===== tb/atwr_readout_test.sv
/*
 * atwr_readout_test: self-checking bench for the readout block.
 * assumes shortened timing parameters and a host model on the link.
 */
`timescale 1ns/1ps
module atwr_readout_test;
    import atwr_pkg::*;
    localparam int         ST = 200;
    localparam int         SE = 2000;
    localparam int         PE = 1500;
    localparam int         GU = 100;
    // identification value is arbitrary
    localparam logic [1:0] ID_TB = 2'h3;

    typedef struct packed {
        logic [15:0] code;
        logic        err;
        logic [23:0] exp;
    } atwr_row_s;
    // result rows with the serial word each should give
    atwr_row_s rows [4] = '{'{16'h0000, 1'b0, 24'h00001D},
                            '{16'h8000, 1'b1, 24'h80003D},
                            '{16'hFFFF, 1'b0, 24'hFFFF1D},
                            '{16'h1234, 1'b1, 24'h12343D}};

    logic         clk_sys;
    logic         rst;
    logic         psel;
    logic         penable;
    logic         pwrite;
    logic [7:0]   paddr;
    logic [31:0]  pwdata;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    atwr_result_s filt;
    logic         pd_n;
    logic         sclk;
    logic         dout_o;
    logic         dout_oe;
    wire          pin = dout_oe ? dout_o : 1'bz;
    int           num_errors = 0;
    int           tests_run = 0;
    int           n;
    int           n2;
    logic [31:0]  rd;
    logic         er;
    logic [23:0]  w;
    logic         seen;
    logic         ok;

    // system clock, 4 ns
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    atwr_readout #(.STARTUP_C(ST), .SETTLE_C(SE), .PERIOD_C(PE),
                   .GUARD_C(GU), .IDENT(ID_TB)) dut (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .filt_result(filt),
        .powerdown_reset_n(pd_n), .sclk(sclk),
        .data_out_ready_n_o(dout_o), .data_out_ready_n_oe(dout_oe));

    atwr_host host (.sclk(sclk), .dout(pin));

    // one comparison, counted
    task automatic check(input logic good, input string msg);
        tests_run++;
        if (!good) begin
            num_errors++;
            $display("unexpected %0t: %s", $time, msg);
        end
    endtask

    // one apb transfer, waits for pready; the watchdog ends a hang
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // cycles until the pin shows a level, at most lim
    task automatic wait_pin(input logic lvl, input int lim, output int c);
        c = 0;
        while (pin !== lvl && c < lim) begin
            @(posedge clk_sys);
            #1; // look once the edge's updates have settled
            c++;
        end
    endtask

    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // watchdog against a hung handshake
    initial begin
        #200000;
        num_errors++;
        $display("unexpected %0t: watchdog expired", $time);
        end_of_test();
    end

    // main sequence
    initial begin
        rst <= 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h00000000;
        filt <= atwr_result_s'{rows[0].code, rows[0].err};
        pd_n <= 1'b1;
        repeat (16) @(posedge clk_sys);
        check(dout_oe === 1'b0 && dout_o === 1'b1 && pready === 1'b1 &&
              prdata === 32'h0 && pslverr === 1'b0, "reset outputs");
        rst <= 1'b0;
        apb(1'b0, OFS_CTRL, 32'h0);
        check(rd === 32'h00000000 && er === 1'b0, "ctrl reset value");
        repeat (300) @(posedge clk_sys);
        check(dout_oe === 1'b1 && dout_o === 1'b1, "idle high");
        wait_pin(1'b0, 3000, n);
        check(n + 305 >= SE && n + 300 <= ST + SE + 20, "first");
        $display("test power-up done");
        // ordinary rows, one read each
        foreach (rows[i]) begin
            host.read_word(20000, w, seen, ok);
            check(seen === 1'b1 && w === rows[i].exp, "word");
            check(ok === 1'b1, "transfer check");
            wait_pin(1'b1, 20, n);
            check(n < 20, "pin high after read");
            @(posedge clk_sys);
            filt <= atwr_result_s'{rows[(i + 1) % 4].code,
                                   rows[(i + 1) % 4].err};
            wait_pin(1'b0, 300, n);
            check(n === 300, "word offered twice");
        end
        $display("test rows done");
        apb(1'b0, OFS_RESULT, 32'h0);
        check(rd === 32'h00071234 && er === 1'b0, "result reg");
        apb(1'b0, 8'h10, 32'h0);
        check(rd === 32'h0 && er === 1'b1, "unmapped");
        // four completions so far, word read, link idle and running
        apb(1'b0, OFS_COUNT, 32'h0);
        check(rd === 32'h00000004 && er === 1'b0, "completion count");
        apb(1'b0, OFS_STATUS, 32'h0);
        check(rd === 32'h00000003 && er === 1'b0, "status idle");
        apb(1'b1, OFS_STATUS, 32'hFFFFFFFF);
        check(er === 1'b0, "status write");
        $display("test registers done");
        // unread word: pin raised ahead of update, then low again
        wait_pin(1'b0, 2000, n);
        wait_pin(1'b1, 2000, n);
        check(n >= PE - GU - 8 && n <= PE - GU + 8, "guard");
        wait_pin(1'b0, 2000, n2);
        check(n + n2 >= PE - 8 && n + n2 <= PE + 8, "rate");
        $display("test unread done");
        // power-down pin held 30 cycles
        @(posedge clk_sys);
        pd_n <= 1'b0; // held past 100 ns
        repeat (30) @(posedge clk_sys);
        check(dout_oe === 1'b0, "tristate");
        pd_n <= 1'b1;
        repeat (300) @(posedge clk_sys);
        check(dout_oe === 1'b1 && dout_o === 1'b1, "wake high");
        wait_pin(1'b0, 3000, n);
        check(n + 300 >= SE, "settle again");
        $display("test power-down done");
        // software hold behaves as the pin
        apb(1'b1, OFS_CTRL, 32'h1);
        apb(1'b0, OFS_CTRL, 32'h0);
        check(rd === 32'h00000001, "hold readback");
        repeat (40) @(posedge clk_sys);
        check(dout_oe === 1'b0, "hold tristate");
        apb(1'b1, OFS_CTRL, 32'h0);
        $display("test hold done");
        end_of_test();
    end
endmodule
